// ==== hw/c8x_pkg.sv ====
// shared constants, opcodes and carrier types of the cpu8 execution block
`default_nettype none
package c8x_pkg;

    typedef logic [15:0] c8x_addr_t;

    // instruction classes handled by this block
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_INC = 4'h1,
        OP_LSL = 4'h2,
        OP_LSR = 4'h3,
        OP_NEG = 4'h4,
        OP_ROL = 4'h5,
        OP_LDA = 4'h6,
        OP_LDX = 4'h7,
        OP_ORA = 4'h8,
        OP_MUL = 4'h9,
        OP_JMP = 4'hA,
        OP_JSR = 4'hB
    } c8x_op_e;

    // operand addressing modes
    typedef enum logic [2:0] {
        MD_INHA = 3'h0,
        MD_INHX = 3'h1,
        MD_IMM  = 3'h2,
        MD_DIR  = 3'h3,
        MD_EXT  = 3'h4,
        MD_IX   = 3'h5,
        MD_IX1  = 3'h6,
        MD_IX2  = 3'h7
    } c8x_mode_e;

    typedef struct packed {
        c8x_op_e     op;
        c8x_mode_e   mode;
        logic [1:0]  nbytes;
        logic [3:0]  cyc;
        logic        rmw;
    } c8x_dec_s;

    typedef struct packed {
        logic h;
        logic i;
        logic n;
        logic z;
        logic c;
    } c8x_ccr_s;

    typedef struct packed {
        c8x_addr_t   addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
    } c8x_mem_s;

    localparam c8x_ccr_s CCR_RESET = 5'h08;

    // opcode high nibble selects the addressing mode
    localparam logic [3:0] HI_RMW_DIR = 4'h3;
    localparam logic [3:0] HI_INHA    = 4'h4;
    localparam logic [3:0] HI_INHX    = 4'h5;
    localparam logic [3:0] HI_RMW_IX1 = 4'h6;
    localparam logic [3:0] HI_RMW_IX  = 4'h7;
    localparam logic [3:0] HI_IMM     = 4'hA;
    localparam logic [3:0] HI_DIR     = 4'hB;
    localparam logic [3:0] HI_EXT     = 4'hC;
    localparam logic [3:0] HI_IX2     = 4'hD;
    localparam logic [3:0] HI_IX1     = 4'hE;
    localparam logic [3:0] HI_IX      = 4'hF;

    // opcode low nibble selects the operation
    localparam logic [3:0] LO_NEG = 4'h0;
    localparam logic [3:0] LO_LSR = 4'h4;
    localparam logic [3:0] LO_LSL = 4'h8;
    localparam logic [3:0] LO_ROL = 4'h9;
    localparam logic [3:0] LO_INC = 4'hC;
    localparam logic [3:0] LO_LDA = 4'h6;
    localparam logic [3:0] LO_ORA = 4'hA;
    localparam logic [3:0] LO_JMP = 4'hC;
    localparam logic [3:0] LO_JSR = 4'hD;
    localparam logic [3:0] LO_LDX = 4'hE;
    localparam logic [7:0] OPC_MUL = 8'h42;
    localparam logic [7:0] OPC_NOP = 8'h9D;

    // cycle counts per class and mode
    localparam logic [3:0] CYC_RMW_INH = 4'h3;
    localparam logic [3:0] CYC_RMW_DIR = 4'h5;
    localparam logic [3:0] CYC_RMW_IX  = 4'h5;
    localparam logic [3:0] CYC_RMW_IX1 = 4'h6;
    localparam logic [3:0] CYC_RD_IMM  = 4'h2;
    localparam logic [3:0] CYC_RD_DIR  = 4'h3;
    localparam logic [3:0] CYC_RD_EXT  = 4'h4;
    localparam logic [3:0] CYC_RD_IX   = 4'h3;
    localparam logic [3:0] CYC_RD_IX1  = 4'h4;
    localparam logic [3:0] CYC_RD_IX2  = 4'h5;
    localparam logic [3:0] CYC_JMP_DIR = 4'h2;
    localparam logic [3:0] CYC_JMP_EXT = 4'h3;
    localparam logic [3:0] CYC_JMP_IX  = 4'h2;
    localparam logic [3:0] CYC_JMP_IX1 = 4'h3;
    localparam logic [3:0] CYC_JMP_IX2 = 4'h4;
    localparam logic [3:0] CYC_JSR_ADD = 4'h3;
    localparam logic [3:0] CYC_MUL     = 4'hB;
    localparam logic [3:0] CYC_NOP     = 4'h2;

endpackage
`default_nettype wire

// ==== hw/c8x_alu.sv ====
// combinational result and flag unit of the cpu8 execution block
`timescale 1ns/1ns
`default_nettype none
module c8x_alu #(
    parameter int W = 8
) (
    input  wire c8x_pkg::c8x_op_e i_op,
    input  wire logic [W-1:0]     i_acc,
    input  wire logic [W-1:0]     i_idx,
    input  wire logic [W-1:0]     i_opnd,
    input  wire logic             i_carry,
    output logic      [W-1:0]     o_res,
    output logic      [W-1:0]     o_res_hi,
    output logic                  o_neg,
    output logic                  o_zero,
    output logic                  o_carry
);
    logic [2*W-1:0] prod;

    always_comb begin
        prod     = (2*W)'(i_idx) * (2*W)'(i_acc);
        o_res    = i_opnd;
        o_res_hi = '0;
        o_carry  = i_carry;
        unique case (i_op)
            c8x_pkg::OP_INC: o_res = W'(i_opnd + 1'b1);
            c8x_pkg::OP_LSL: begin
                o_res   = {i_opnd[W-2:0], 1'b0};
                o_carry = i_opnd[W-1];
            end
            c8x_pkg::OP_LSR: begin
                o_res   = {1'b0, i_opnd[W-1:1]};
                o_carry = i_opnd[0];
            end
            c8x_pkg::OP_NEG: begin
                o_res   = W'(~i_opnd + 1'b1);
                o_carry = |i_opnd;
            end
            c8x_pkg::OP_ROL: begin
                o_res   = {i_opnd[W-2:0], i_carry};
                o_carry = i_opnd[W-1];
            end
            c8x_pkg::OP_ORA: o_res = i_acc | i_opnd;
            c8x_pkg::OP_MUL: begin
                o_res    = prod[W-1:0];
                o_res_hi = prod[2*W-1:W];
                o_carry  = 1'b0;
            end
            default: o_res = i_opnd;
        endcase
        // lsr result always has a clear top bit, so this also clears n there
        o_neg  = o_res[W-1];
        o_zero = (o_res == '0);
    end
endmodule // c8x_alu
`default_nettype wire

// ==== hw/c8x_core.sv ====
// cpu8 execution core: fetch, decode and execute of twelve instructions
//
// Behaviour
// - increment a, x or memory; n z, c kept
// - n is result bit 7; z when zero
// - jump loads effective address; flags untouched
// - call advances pc, pushes low then high
// - unimplemented pc high bits pushed as ones
// - stack pointer always names next empty slot
// - load accumulator sets n z, keeps carry
// - load index sets n z, keeps carry
// - shift left, zero in, bit 7 to carry
// - shift right, zero in, n cleared
// - x times a into x:a, eleven cycles
// - negate to twos complement; 80 stays 80
// - negate carry set unless operand was zero
// - idle is one byte, two cycles, pc only
// - or into accumulator; n z, carry kept
// - rotate left through carry; n z updated
`timescale 1ns/1ns
`default_nettype none
module c8x_core #(
    parameter int           PC_W     = 13,
    parameter logic [15:0]  RESET_PC = 16'h0000,
    parameter logic [15:0]  SP_TOP   = 16'h00FF
) (
    input  wire logic               i_clk_sys,
    input  wire logic               i_rst_b,
    input  wire logic [7:0]         i_mem_rdata,
    output c8x_pkg::c8x_mem_s       o_mem,
    output logic                    o_fetch,
    output logic [7:0]              o_accumulator,
    output logic [7:0]              o_index,
    output c8x_pkg::c8x_ccr_s       o_condition_code_register,
    output logic [PC_W-1:0]         o_program_counter,
    output logic [PC_W-1:0]         o_stack_pointer
);
    typedef enum logic [7:0] {
        S_FETCH = 8'b0000_0001,
        S_OP1   = 8'b0000_0010,
        S_OP2   = 8'b0000_0100,
        S_EXEC  = 8'b0000_1000,
        S_WRITE = 8'b0001_0000,
        S_PUSHL = 8'b0010_0000,
        S_PUSHH = 8'b0100_0000,
        S_PAD   = 8'b1000_0000
    } c8x_state_e;

    c8x_state_e         st_r,  st_nxt;
    logic [PC_W-1:0]    pc_r,  pc_nxt;
    logic [PC_W-1:0]    sp_r,  sp_nxt;
    logic [PC_W-1:0]    ea_r,  ea_nxt;
    logic [7:0]         acc_r, acc_nxt;
    logic [7:0]         idx_r, idx_nxt;
    logic [7:0]         b1_r,  b1_nxt;
    logic [7:0]         res_r, res_nxt;
    logic [3:0]         cnt_r, cnt_nxt;
    c8x_pkg::c8x_ccr_s  ccr_r, ccr_nxt;
    c8x_pkg::c8x_dec_s  dec_r, dec_nxt;

    c8x_pkg::c8x_dec_s  dec;
    c8x_pkg::c8x_dec_s  cur;
    c8x_state_e         fin_st;
    logic [PC_W-1:0]    ea;
    logic [15:0]        pc_ext;
    logic [7:0]         alu_opnd;
    logic [7:0]         alu_res;
    logic [7:0]         alu_hi;
    logic               alu_n;
    logic               alu_z;
    logic               alu_c;
    logic               addr_last;
    logic               exec_now;

    // map an opcode to class, mode, operand byte count and total cycles
    function automatic c8x_pkg::c8x_dec_s decode(input logic [7:0] opc);
        c8x_pkg::c8x_dec_s d;
        logic              rd_grp;
        d      = '{op: c8x_pkg::OP_NOP, mode: c8x_pkg::MD_INHA,
                   nbytes: 2'd0, cyc: c8x_pkg::CYC_NOP, rmw: 1'b0};
        rd_grp = 1'b0;
        unique case (opc[3:0])
            c8x_pkg::LO_NEG: d.op = c8x_pkg::OP_NEG;
            c8x_pkg::LO_LSR: d.op = c8x_pkg::OP_LSR;
            c8x_pkg::LO_LSL: d.op = c8x_pkg::OP_LSL;
            c8x_pkg::LO_ROL: d.op = c8x_pkg::OP_ROL;
            c8x_pkg::LO_INC: d.op = c8x_pkg::OP_INC;
            default:         d.op = c8x_pkg::OP_NOP;
        endcase
        d.rmw = (d.op != c8x_pkg::OP_NOP);
        unique case (opc[7:4])
            c8x_pkg::HI_INHA:    begin d.mode = c8x_pkg::MD_INHA; d.cyc = c8x_pkg::CYC_RMW_INH; end
            c8x_pkg::HI_INHX:    begin d.mode = c8x_pkg::MD_INHX; d.cyc = c8x_pkg::CYC_RMW_INH; end
            c8x_pkg::HI_RMW_DIR: begin d.mode = c8x_pkg::MD_DIR;  d.cyc = c8x_pkg::CYC_RMW_DIR; end
            c8x_pkg::HI_RMW_IX:  begin d.mode = c8x_pkg::MD_IX;   d.cyc = c8x_pkg::CYC_RMW_IX;  end
            c8x_pkg::HI_RMW_IX1: begin d.mode = c8x_pkg::MD_IX1;  d.cyc = c8x_pkg::CYC_RMW_IX1; end
            default:             begin rd_grp = 1'b1; d.rmw = 1'b0; end
        endcase
        if (rd_grp) begin
            unique case (opc[3:0])
                c8x_pkg::LO_LDA: d.op = c8x_pkg::OP_LDA;
                c8x_pkg::LO_LDX: d.op = c8x_pkg::OP_LDX;
                c8x_pkg::LO_ORA: d.op = c8x_pkg::OP_ORA;
                c8x_pkg::LO_JMP: d.op = c8x_pkg::OP_JMP;
                c8x_pkg::LO_JSR: d.op = c8x_pkg::OP_JSR;
                default:         d.op = c8x_pkg::OP_NOP;
            endcase
            unique case (opc[7:4])
                c8x_pkg::HI_IMM: begin d.mode = c8x_pkg::MD_IMM; d.cyc = c8x_pkg::CYC_RD_IMM; end
                c8x_pkg::HI_DIR: begin d.mode = c8x_pkg::MD_DIR; d.cyc = c8x_pkg::CYC_RD_DIR; end
                c8x_pkg::HI_EXT: begin d.mode = c8x_pkg::MD_EXT; d.cyc = c8x_pkg::CYC_RD_EXT; end
                c8x_pkg::HI_IX2: begin d.mode = c8x_pkg::MD_IX2; d.cyc = c8x_pkg::CYC_RD_IX2; end
                c8x_pkg::HI_IX1: begin d.mode = c8x_pkg::MD_IX1; d.cyc = c8x_pkg::CYC_RD_IX1; end
                c8x_pkg::HI_IX:  begin d.mode = c8x_pkg::MD_IX;  d.cyc = c8x_pkg::CYC_RD_IX;  end
                default:         d.op = c8x_pkg::OP_NOP;
            endcase
            if (d.op == c8x_pkg::OP_JMP || d.op == c8x_pkg::OP_JSR) begin
                unique case (d.mode)
                    c8x_pkg::MD_DIR: d.cyc = c8x_pkg::CYC_JMP_DIR;
                    c8x_pkg::MD_EXT: d.cyc = c8x_pkg::CYC_JMP_EXT;
                    c8x_pkg::MD_IX:  d.cyc = c8x_pkg::CYC_JMP_IX;
                    c8x_pkg::MD_IX1: d.cyc = c8x_pkg::CYC_JMP_IX1;
                    c8x_pkg::MD_IX2: d.cyc = c8x_pkg::CYC_JMP_IX2;
                    default:         d.op  = c8x_pkg::OP_NOP;
                endcase
                if (d.op == c8x_pkg::OP_JSR) begin
                    d.cyc = 4'(d.cyc + c8x_pkg::CYC_JSR_ADD);
                end
            end
        end
        if (opc == c8x_pkg::OPC_MUL) begin
            d.op  = c8x_pkg::OP_MUL;
            d.cyc = c8x_pkg::CYC_MUL;
        end
        if (d.op == c8x_pkg::OP_NOP) begin
            d.mode = c8x_pkg::MD_INHA;
            d.cyc  = c8x_pkg::CYC_NOP;
            d.rmw  = 1'b0;
        end
        unique case (d.mode)
            c8x_pkg::MD_IMM, c8x_pkg::MD_DIR,
            c8x_pkg::MD_IX1:                  d.nbytes = 2'd1;
            c8x_pkg::MD_EXT, c8x_pkg::MD_IX2: d.nbytes = 2'd2;
            default:                          d.nbytes = 2'd0;
        endcase
        return d;
    endfunction

    c8x_alu #(
        .W        (8)
    ) u_alu (
        .i_op     (cur.op),
        .i_acc    (acc_r),
        .i_idx    (idx_r),
        .i_opnd   (alu_opnd),
        .i_carry  (ccr_r.c),
        .o_res    (alu_res),
        .o_res_hi (alu_hi),
        .o_neg    (alu_n),
        .o_zero   (alu_z),
        .o_carry  (alu_c)
    );

    always_comb begin
        dec      = decode(i_mem_rdata);
        cur      = (st_r == S_FETCH) ? dec : dec_r;
        alu_opnd = (cur.mode == c8x_pkg::MD_INHA) ? acc_r :
                   (cur.mode == c8x_pkg::MD_INHX) ? idx_r : i_mem_rdata;
        // each instruction is padded out to its listed cycle count
        fin_st   = (5'(cnt_r) + 5'd1 >= 5'(cur.cyc)) ? S_FETCH : S_PAD;
        pc_ext   = {{(16-PC_W){1'b1}}, pc_r};
        unique case (cur.mode)
            c8x_pkg::MD_DIR: ea = PC_W'(i_mem_rdata);
            c8x_pkg::MD_EXT: ea = PC_W'({b1_r, i_mem_rdata});
            c8x_pkg::MD_IX:  ea = PC_W'(idx_r);
            c8x_pkg::MD_IX1: ea = PC_W'(9'(idx_r) + 9'(i_mem_rdata));
            c8x_pkg::MD_IX2: ea = PC_W'(17'({b1_r, i_mem_rdata}) + 17'(idx_r));
            default:         ea = '0;
        endcase
        unique case (st_r)
            S_FETCH: addr_last = (dec.nbytes == 2'd0);
            S_OP1:   addr_last = (dec_r.nbytes == 2'd1);
            S_OP2:   addr_last = 1'b1;
            default: addr_last = 1'b0;
        endcase

        st_nxt   = st_r;
        pc_nxt   = pc_r;
        sp_nxt   = sp_r;
        ea_nxt   = ea_r;
        acc_nxt  = acc_r;
        idx_nxt  = idx_r;
        b1_nxt   = b1_r;
        res_nxt  = res_r;
        ccr_nxt  = ccr_r;
        dec_nxt  = dec_r;
        exec_now = 1'b0;
        o_mem    = '0;
        o_fetch  = 1'b0;

        unique case (st_r)
            S_FETCH: begin
                o_mem.addr = c8x_pkg::c8x_addr_t'(pc_r);
                o_mem.rd   = 1'b1;
                o_fetch    = 1'b1;
                pc_nxt     = PC_W'(pc_r + 1'b1);
                dec_nxt    = dec;
                st_nxt     = S_OP1;
            end
            S_OP1, S_OP2: begin
                o_mem.addr = c8x_pkg::c8x_addr_t'(pc_r);
                o_mem.rd   = 1'b1;
                pc_nxt     = PC_W'(pc_r + 1'b1);
                b1_nxt     = i_mem_rdata;
                st_nxt     = S_OP2;
            end
            S_EXEC: begin
                o_mem.addr = c8x_pkg::c8x_addr_t'(ea_r);
                o_mem.rd   = !(cur.mode == c8x_pkg::MD_INHA || cur.mode == c8x_pkg::MD_INHX);
                exec_now   = 1'b1;
                st_nxt     = (cur.rmw && o_mem.rd) ? S_WRITE : fin_st;
            end
            S_WRITE: begin
                o_mem.addr  = c8x_pkg::c8x_addr_t'(ea_r);
                o_mem.wdata = res_r;
                o_mem.wr    = 1'b1;
                st_nxt      = fin_st;
            end
            S_PUSHL: begin
                o_mem.addr  = c8x_pkg::c8x_addr_t'(sp_r);
                o_mem.wdata = pc_ext[7:0];
                o_mem.wr    = 1'b1;
                sp_nxt      = PC_W'(sp_r - 1'b1);
                st_nxt      = S_PUSHH;
            end
            S_PUSHH: begin
                o_mem.addr  = c8x_pkg::c8x_addr_t'(sp_r);
                o_mem.wdata = pc_ext[15:8];
                o_mem.wr    = 1'b1;
                sp_nxt      = PC_W'(sp_r - 1'b1);
                pc_nxt      = ea_r;
                st_nxt      = fin_st;
            end
            S_PAD: begin
                st_nxt = fin_st;
            end
        endcase

        // addressing is complete once the last operand byte is on the bus
        if (addr_last) begin
            unique case (cur.op)
                c8x_pkg::OP_NOP: st_nxt = fin_st;
                c8x_pkg::OP_JMP: begin
                    pc_nxt = ea;
                    st_nxt = fin_st;
                end
                c8x_pkg::OP_JSR: begin
                    ea_nxt = ea;
                    st_nxt = S_PUSHL;
                end
                default: begin
                    if (cur.mode == c8x_pkg::MD_IMM) begin
                        exec_now = 1'b1;
                        st_nxt   = fin_st;
                    end else begin
                        ea_nxt = ea;
                        st_nxt = S_EXEC;
                    end
                end
            endcase
        end

        if (exec_now) begin
            // carry follows the unit, which passes it through where untouched
            ccr_nxt.c = alu_c;
            if (cur.op == c8x_pkg::OP_MUL) begin
                ccr_nxt.h = 1'b0;
                idx_nxt   = alu_hi;
                acc_nxt   = alu_res;
            end else begin
                ccr_nxt.n = alu_n;
                ccr_nxt.z = alu_z;
                if (cur.op == c8x_pkg::OP_LDX) begin
                    idx_nxt = alu_res;
                end else if (cur.mode == c8x_pkg::MD_INHX) begin
                    idx_nxt = alu_res;
                end else if (cur.rmw && cur.mode != c8x_pkg::MD_INHA) begin
                    res_nxt = alu_res;
                end else begin
                    acc_nxt = alu_res;
                end
            end
        end

        cnt_nxt = (st_nxt == S_FETCH) ? 4'h0 : 4'(cnt_r + 1'b1);
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r  <= S_FETCH;
            pc_r  <= PC_W'(RESET_PC);
            sp_r  <= PC_W'(SP_TOP);
            ea_r  <= '0;
            acc_r <= 8'h00;
            idx_r <= 8'h00;
            b1_r  <= 8'h00;
            res_r <= 8'h00;
            cnt_r <= 4'h0;
            ccr_r <= c8x_pkg::CCR_RESET;
            dec_r <= '0;
        end else begin
            st_r  <= st_nxt;
            pc_r  <= pc_nxt;
            sp_r  <= sp_nxt;
            ea_r  <= ea_nxt;
            acc_r <= acc_nxt;
            idx_r <= idx_nxt;
            b1_r  <= b1_nxt;
            res_r <= res_nxt;
            cnt_r <= cnt_nxt;
            ccr_r <= ccr_nxt;
            dec_r <= dec_nxt;
        end
    end

    assign o_accumulator             = acc_r;
    assign o_index                   = idx_r;
    assign o_condition_code_register = ccr_r;
    assign o_program_counter         = pc_r;
    assign o_stack_pointer           = sp_r;
endmodule // c8x_core
`default_nettype wire

// ==== testbench/c8x_chk.sv ====
// assertion checker for the cpu8 execution core
`timescale 1ns/1ns
`default_nettype none
module c8x_chk #(
    parameter int PC_W = 13
) (
    input wire logic              i_clk_sys,
    input wire logic              i_rst_b,
    input wire logic [7:0]        i_mem_rdata,
    input wire c8x_pkg::c8x_mem_s o_mem,
    input wire logic              o_fetch,
    input wire logic [7:0]        o_accumulator,
    input wire logic [7:0]        o_index,
    input wire c8x_pkg::c8x_ccr_s o_condition_code_register,
    input wire logic [PC_W-1:0]   o_program_counter,
    input wire logic [PC_W-1:0]   o_stack_pointer
);
    // high-byte bits above the counter width
    localparam logic [7:0] HI_FILL = 8'hFF << (PC_W - 8);
    wire c8x_pkg::c8x_ccr_s condition_code_register = o_condition_code_register;
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_op(logic [7:0] v);
        o_fetch && i_mem_rdata == v;
    endsequence
    sequence s_two_reads;
        o_mem.rd ##1 o_mem.rd;
    endsequence
    a_lda_flags: assert property (s_op(8'hA6) |=> ##1
        o_accumulator == $past(i_mem_rdata) && condition_code_register.n == o_accumulator[7] &&
        condition_code_register.z == (o_accumulator == 8'h00) && condition_code_register.c == $past(condition_code_register.c, 2))
        else $error("load accumulator wrong");
    a_neg_carry: assert property (s_op(8'h40) |=> ##1
        o_accumulator == 8'(8'h00 - $past(o_accumulator, 2)) &&
        condition_code_register.c == ($past(o_accumulator, 2) != 8'h00)) else $error("negate wrong");
    a_lsl_carry: assert property (s_op(8'h48) |=> ##1
        o_accumulator == {$past(o_accumulator[6:0], 2), 1'b0} &&
        condition_code_register.c == $past(o_accumulator[7], 2)) else $error("shift left wrong");
    a_lsr_nclear: assert property (s_op(8'h44) |=> ##1
        o_accumulator == {1'b0, $past(o_accumulator[7:1], 2)} && !condition_code_register.n &&
        condition_code_register.c == $past(o_accumulator[0], 2)) else $error("shift right wrong");
    a_rol_carry: assert property (s_op(8'h49) |=> ##1
        o_accumulator == {$past(o_accumulator[6:0], 2), $past(condition_code_register.c, 2)} &&
        condition_code_register.c == $past(o_accumulator[7], 2)) else $error("rotate wrong");
    a_mul_cycles: assert property (s_op(8'h42) |=>
        (!o_fetch)[*8] ##1 (!o_fetch)[*2] ##1 o_fetch) else $error("multiply length wrong");
    a_mul_result: assert property (s_op(8'h42) |=> ##1
        {o_index, o_accumulator} == 16'($past(o_index, 2)) * 16'($past(o_accumulator, 2))
        && !condition_code_register.h && !condition_code_register.c) else $error("multiply result wrong");
    a_nop_pc_only: assert property (s_op(8'h9D) |=> !o_fetch ##1 o_fetch &&
        o_program_counter == $past(o_program_counter, 2) + 1'b1 &&
        o_accumulator == $past(o_accumulator, 2) && condition_code_register == $past(condition_code_register, 2))
        else $error("idle changed state");
    a_jmp_target: assert property (s_op(8'hCC) |=> s_two_reads ##1 o_fetch &&
        o_program_counter == PC_W'({$past(i_mem_rdata, 2), $past(i_mem_rdata)}) &&
        condition_code_register == $past(condition_code_register, 3)) else $error("jump wrong");
    a_call_push: assert property (s_op(8'hCD) |=> s_two_reads ##1
        (o_mem.wr && o_mem.addr == 16'($past(o_stack_pointer, 3)) &&
        o_mem.wdata == 8'($past(o_program_counter, 3) + 2'h3)) ##1
        (o_mem.wr && (o_mem.wdata & HI_FILL) == HI_FILL &&
        o_mem.addr == 16'($past(o_stack_pointer, 4) - 1'b1)) ##2
        o_stack_pointer == $past(o_stack_pointer, 6) - 2'h2) else $error("call push wrong");
endmodule // c8x_chk
bind c8x_core c8x_chk #(.PC_W(PC_W)) c8x_chk_inst (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_mem_rdata(i_mem_rdata), .o_mem(o_mem),
    .o_fetch(o_fetch), .o_accumulator(o_accumulator), .o_index(o_index),
    .o_condition_code_register(o_condition_code_register),
    .o_program_counter(o_program_counter), .o_stack_pointer(o_stack_pointer));
`default_nettype wire

// ==== testbench/c8x_core_tb_top.sv ====
// self-checking bench running a short program through the cpu8 core
`timescale 1ns/1ns
`default_nettype none
module c8x_core_tb_top;
    logic              i_clk_sys = 1'b0;
    logic              i_rst_b = 1'b0;
    logic [7:0]        i_mem_rdata = 8'h00;
    c8x_pkg::c8x_mem_s o_mem;
    logic              o_fetch;
    logic [7:0]        acc;
    logic [7:0]        idx;
    c8x_pkg::c8x_ccr_s condition_code_register;
    logic [12:0]       pc;
    logic [12:0]       sp;
    logic [7:0]        mem [0:65535];
    logic [159:0]      prog = 160'hA680_4048_49AE_0DA6_F148_4244_AA81_3C40_9DCD_0100;
    logic [95:0]       tail = 96'h40A6_0040_5CF6_E635_DA00_40FC;
    int                n_fail = 0;
    int                check_count = 0;
    int                cycles = 0;

    always #20 i_clk_sys = ~i_clk_sys;

    c8x_core c8x_core_inst (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_mem_rdata(i_mem_rdata), .o_mem(o_mem), .o_fetch(o_fetch), .o_accumulator(acc),
        .o_index(idx), .o_condition_code_register(condition_code_register), .o_program_counter(pc),
        .o_stack_pointer(sp));

    // read data follows the address, settled well before the sampling edge
    always @(negedge i_clk_sys) i_mem_rdata <= mem[o_mem.addr];
    always @(posedge i_clk_sys) begin
        if (o_mem.wr === 1'b1) mem[o_mem.addr] <= o_mem.wdata;
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            test_done();
        end
    end

    task test_done;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task nzc(input logic [2:0] e);
        chk("n z c", 16'(e), 16'({condition_code_register.n, condition_code_register.z, condition_code_register.c}));
    endtask

    // one instruction, counted from its fetch to the next fetch
    task run(input logic [3:0] cyc);
        int n;
        n = 0;
        do begin
            @(negedge i_clk_sys);
            n++;
        end while (o_fetch !== 1'b1 && n < 20);
        chk("cycles", 16'(cyc), 16'(n));
    endtask

    task t_load_neg;
        chk("sp reset", 16'h00FF, 16'(sp));
        chk("ccr reset", 16'h0008, 16'(condition_code_register));
        run(c8x_pkg::CYC_RD_IMM);
        chk("acc", 16'h0080, 16'(acc));
        nzc(3'h4);
        run(c8x_pkg::CYC_RMW_INH);
        chk("acc", 16'h0080, 16'(acc));
        nzc(3'h5);
        $display("test load_neg done");
    endtask

    task t_shift_rotate;
        run(c8x_pkg::CYC_RMW_INH);
        chk("acc", 16'h0000, 16'(acc));
        nzc(3'h3);
        run(c8x_pkg::CYC_RMW_INH);
        chk("acc", 16'h0001, 16'(acc));
        nzc(3'h0);
        $display("test shift_rotate done");
    endtask

    task t_product;
        run(c8x_pkg::CYC_RD_IMM);
        chk("idx", 16'h000D, 16'(idx));
        run(c8x_pkg::CYC_RD_IMM);
        run(c8x_pkg::CYC_RMW_INH);
        nzc(3'h5);
        run(c8x_pkg::CYC_MUL);
        chk("x:a", 16'h0B7A, {idx, acc});
        chk("h", 16'h0000, 16'(condition_code_register.h));
        nzc(3'h4);
        $display("test product done");
    endtask

    task t_logic_inc;
        run(c8x_pkg::CYC_RMW_INH);
        chk("acc", 16'h003D, 16'(acc));
        nzc(3'h0);
        run(c8x_pkg::CYC_RD_IMM);
        chk("acc", 16'h00BD, 16'(acc));
        nzc(3'h4);
        run(c8x_pkg::CYC_RMW_DIR);
        chk("mem 40", 16'h0000, 16'(mem[16'h0040]));
        nzc(3'h2);
        $display("test logic_inc done");
    endtask

    task t_idle_call;
        run(c8x_pkg::CYC_NOP);
        chk("pc", 16'h0011, 16'(pc));
        chk("acc", 16'h00BD, 16'(acc));
        run(c8x_pkg::CYC_JMP_EXT + c8x_pkg::CYC_JSR_ADD);
        chk("pc", 16'h0100, 16'(pc));
        chk("sp", 16'h00FD, 16'(sp));
        chk("push low", 16'h0014, 16'(mem[16'h00FF]));
        chk("push high", 16'h00E0, 16'(mem[16'h00FE]));
        $display("test idle_call done");
    endtask

    task t_jump_load;
        run(c8x_pkg::CYC_JMP_EXT);
        chk("pc", 16'h0200, 16'(pc));
        nzc(3'h2);
        run(c8x_pkg::CYC_RD_EXT);
        chk("acc", 16'h005A, 16'(acc));
        run(c8x_pkg::CYC_RMW_INH);
        nzc(3'h5);
        run(c8x_pkg::CYC_RD_IMM);
        nzc(3'h3);
        run(c8x_pkg::CYC_RMW_INH);
        nzc(3'h2);
        $display("test jump_load done");
    endtask

    // index forms: implied x, plain indexed, both offsets, indexed jump
    task t_index_modes;
        run(c8x_pkg::CYC_RMW_INH);
        chk("idx", 16'h000C, 16'(idx));
        run(c8x_pkg::CYC_RD_IX);
        chk("acc", 16'h00AA, 16'(acc));
        nzc(3'h4);
        run(c8x_pkg::CYC_RD_IX1);
        chk("acc", 16'h005A, 16'(acc));
        run(c8x_pkg::CYC_RD_IX2);
        chk("acc", 16'h00DB, 16'(acc));
        run(c8x_pkg::CYC_JMP_IX);
        chk("pc", 16'h000C, 16'(pc));
        $display("test index_modes done");
    endtask

    initial begin
        foreach (mem[k]) mem[k] = 8'h00;
        for (int k = 0; k < 20; k++) mem[k] = prog[159-8*k -: 8];
        mem[16'h0040] = 8'hFF;
        mem[16'h0041] = 8'h5A;
        {mem[16'h0100], mem[16'h0101], mem[16'h0102]} = 24'hCC0200;
        {mem[16'h0200], mem[16'h0201], mem[16'h0202]} = 24'hC60041;
        mem[16'h004C] = 8'h81;
        for (int k = 0; k < 12; k++) mem[16'h0203 + k] = tail[95-8*k -: 8];
        repeat (4) @(negedge i_clk_sys);
        i_rst_b = 1'b1;
        t_load_neg();
        t_shift_rotate();
        t_product();
        t_logic_inc();
        t_idle_call();
        t_jump_load();
        t_index_modes();
        test_done();
    end
endmodule // c8x_core_tb_top
`default_nettype wire
